/* File: hdl/debug_link_regs.svh */
// register offsets, key and command codes and frame counts of the two-wire debug link
`ifndef DEBUG_LINK_REGS_SVH
`define DEBUG_LINK_REGS_SVH

// ---------------------------------------------------------------
// debug register select values
// ---------------------------------------------------------------
`define REG_PART_IDENTITY 8'h00
`define REG_SILICON_REVISION 8'h01
`define REG_PROGRAM_ENABLE_KEY 8'h02
`define REG_PROGRAM_DATA_PORT 8'hb4

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RESET_SELECT 8'h00
`define RESET_ENABLE_KEY 8'h00
`define RESET_DATA_PORT 8'h00
`define RESET_BYTE 8'h00

// ---------------------------------------------------------------
// programming enable key, written in this order
// ---------------------------------------------------------------
`define KEY_FIRST 8'h02
`define KEY_SECOND 8'h01

// ---------------------------------------------------------------
// program-memory command codes
// ---------------------------------------------------------------
`define CMD_BLOCK_READ 8'h06
`define CMD_BLOCK_WRITE 8'h07
`define CMD_PAGE_ERASE 8'h08
`define CMD_DEVICE_ERASE 8'h03

// ---------------------------------------------------------------
// frame layout: start pulse, two instruction pulses, eight data pulses
// ---------------------------------------------------------------
`define INSTR_BIT_LAST 4'h1
`define BYTE_BIT_LAST 4'h7
`define FRAME_DATA_FIRST 4'h3
`define FRAME_PULSE_LAST 4'ha
`define COUNT_ZERO 4'h0
`define COUNT_ONE 4'h1

`endif

/* File: hdl/debug_link_pkg.sv */
// types shared by both ends of the two-wire debug link
`default_nettype none

package debug_link_pkg;

  // instruction field, sent lsb first after the start pulse
  typedef enum logic [1:0] {
    INSTR_DATA_READ = 2'b00,
    INSTR_SELECT_WRITE = 2'b01,
    INSTR_DATA_WRITE = 2'b10,
    INSTR_SELECT_READ = 2'b11
  } linkInstr_t;

  typedef enum logic [3:0] {
    DEV_IDLE = 4'b0001,
    DEV_INSTR = 4'b0010,
    DEV_WRITE = 4'b0100,
    DEV_READ = 4'b1000
  } devState_t;

  typedef enum logic [2:0] {
    HOST_IDLE = 3'b001,
    HOST_LOW = 3'b010,
    HOST_HIGH = 3'b100
  } hostState_t;

endpackage

`default_nettype wire

/* File: hdl/debug_link_if.sv */
// two-wire debug link: host-driven clock pin and shared data pin
`timescale 1ns/1ps
`default_nettype none

interface debug_link_if;
  logic debugClockPin;
  logic hostDataOut;
  logic hostDataOe;
  logic devDataOut;
  logic devDataOe;
  logic debugDataPin;

  // the undriven line settles low, standing in for a board pull-down
  assign debugDataPin = hostDataOe ? hostDataOut : (devDataOe ? devDataOut : 1'b0);

  modport device (
    input debugClockPin,
    input debugDataPin,
    output devDataOut,
    output devDataOe
  );

  modport host (
    output debugClockPin,
    output hostDataOut,
    output hostDataOe,
    input debugDataPin
  );
endinterface

`default_nettype wire

/* File: hdl/debug_port_host.sv */
// host end of the debug link: makes the link clock and runs one frame per request
`timescale 1ns/1ps
`default_nettype none
`include "debug_link_regs.svh"

module debug_port_host #(
  parameter int unsigned HALF_CYCLES = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // request from the user
  input wire logic reqValid,
  input wire debug_link_pkg::linkInstr_t reqInstr,
  input wire logic [7:0] reqData,
  output logic reqReady,
  // answer to a read
  output logic rspValid,
  output logic [7:0] rspData,
  // link
  debug_link_if.host link
);

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

  // ---------------------------------------------------------------
  // data pin synchroniser
  // ---------------------------------------------------------------
  logic [2:0] datSync_q, datSync_d;
  logic datLevel_q, datLevel_d;

  always_comb begin
    datSync_d = {datSync_q[1:0], link.debugDataPin};
    datLevel_d = (datSync_q[1] == datSync_q[2]) ? datSync_q[2] : datLevel_q;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      datSync_q <= 3'h0;
      datLevel_q <= 1'b0;
    end else begin
      datSync_q <= datSync_d;
      datLevel_q <= datLevel_d;
    end
  end

  // ---------------------------------------------------------------
  // frame engine
  // ---------------------------------------------------------------
  debug_link_pkg::hostState_t state_q, state_d;
  logic [7:0] halfCnt_q, halfCnt_d;
  logic [3:0] pulse_q, pulse_d;
  logic [10:0] frame_q, frame_d;
  logic isRead_q, isRead_d;
  logic [7:0] rdShift_q, rdShift_d;
  logic clkOut_q, clkOut_d, outBit_q, outBit_d, outOe_q, outOe_d;
  logic ready_q, ready_d, rspValid_q, rspValid_d;
  logic [7:0] rspData_q, rspData_d;
  logic [3:0] nextPulse;

  always_comb begin
    state_d = state_q;
    halfCnt_d = halfCnt_q + 8'h01;
    pulse_d = pulse_q;
    frame_d = frame_q;
    isRead_d = isRead_q;
    rdShift_d = rdShift_q;
    clkOut_d = clkOut_q;
    outBit_d = outBit_q;
    outOe_d = outOe_q;
    ready_d = ready_q;
    rspValid_d = 1'b0;
    rspData_d = rspData_q;
    nextPulse = pulse_q + `COUNT_ONE;
    case (state_q)
      debug_link_pkg::HOST_IDLE: begin
        halfCnt_d = 8'h00;
        if (reqValid && ready_q) begin
          // start pulse carries a one, then instruction and data lsb first
          frame_d = {reqData, reqInstr, 1'b1};
          isRead_d = (reqInstr == debug_link_pkg::INSTR_DATA_READ) ||
                     (reqInstr == debug_link_pkg::INSTR_SELECT_READ);
          pulse_d = `COUNT_ZERO;
          clkOut_d = 1'b0;
          outOe_d = 1'b1;
          outBit_d = 1'b1;
          ready_d = 1'b0;
          state_d = debug_link_pkg::HOST_LOW;
        end
      end
      debug_link_pkg::HOST_LOW: begin
        if (halfCnt_q == HALF_LAST) begin
          halfCnt_d = 8'h00;
          clkOut_d = 1'b1;
          state_d = debug_link_pkg::HOST_HIGH;
          // device bit has stood most of the low half; take it as the clock rises
          if (isRead_q && pulse_q >= `FRAME_DATA_FIRST) begin
            rdShift_d = {datLevel_q, rdShift_q[7:1]};
          end
        end
      end
      debug_link_pkg::HOST_HIGH: begin
        if (halfCnt_q == HALF_LAST) begin
          halfCnt_d = 8'h00;
          if (pulse_q == `FRAME_PULSE_LAST) begin
            outOe_d = 1'b0;
            outBit_d = 1'b0;
            ready_d = 1'b1;
            rspValid_d = isRead_q;
            rspData_d = rdShift_q;
            state_d = debug_link_pkg::HOST_IDLE;
          end else begin
            pulse_d = nextPulse;
            clkOut_d = 1'b0;
            outOe_d = !(isRead_q && nextPulse >= `FRAME_DATA_FIRST);
            outBit_d = outOe_d & frame_q[nextPulse];
            state_d = debug_link_pkg::HOST_LOW;
          end
        end
      end
      default: state_d = debug_link_pkg::HOST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= debug_link_pkg::HOST_IDLE;
      halfCnt_q <= 8'h00;
      pulse_q <= `COUNT_ZERO;
      frame_q <= 11'h000;
      isRead_q <= 1'b0;
      rdShift_q <= `RESET_BYTE;
      clkOut_q <= 1'b1;
      outBit_q <= 1'b0;
      outOe_q <= 1'b0;
      ready_q <= 1'b1;
      rspValid_q <= 1'b0;
      rspData_q <= `RESET_BYTE;
    end else begin
      state_q <= state_d;
      halfCnt_q <= halfCnt_d;
      pulse_q <= pulse_d;
      frame_q <= frame_d;
      isRead_q <= isRead_d;
      rdShift_q <= rdShift_d;
      clkOut_q <= clkOut_d;
      outBit_q <= outBit_d;
      outOe_q <= outOe_d;
      ready_q <= ready_d;
      rspValid_q <= rspValid_d;
      rspData_q <= rspData_d;
    end
  end

  assign link.debugClockPin = clkOut_q;
  assign link.hostDataOut = outBit_q;
  assign link.hostDataOe = outOe_q;
  assign reqReady = ready_q;
  assign rspValid = rspValid_q;
  assign rspData = rspData_q;

endmodule

`default_nettype wire

/* File: hdl/debug_port_device.sv */
// device end of the debug link: frame decoder and the debug register set
`timescale 1ns/1ps
`default_nettype none
`include "debug_link_regs.svh"

module debug_port_device #(
  // arbitrary identity values, not those of any real part
  parameter logic [7:0] PART_ID = 8'h5a,
  parameter logic [7:0] REVISION = 8'h0c
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // core state
  input wire logic coreHalted,
  output logic stallAll,
  output logic programEnabled,
  // program-memory command side
  output logic commandStrobe,
  output logic [7:0] commandCode,
  output logic byteStrobe,
  output logic [7:0] portByte,
  input wire logic flashDone,
  input wire logic [7:0] flashReadData,
  // link
  debug_link_if.device link
);

  // ---------------------------------------------------------------
  // pin synchronisers: three stages, level moves once stages two and three agree
  // ---------------------------------------------------------------
  logic [2:0] clkSync_q, clkSync_d, datSync_q, datSync_d;
  logic clkLevel_q, clkLevel_d, datLevel_q, datLevel_d;
  logic rise, fall;

  always_comb begin
    clkSync_d = {clkSync_q[1:0], link.debugClockPin};
    datSync_d = {datSync_q[1:0], link.debugDataPin};
    clkLevel_d = (clkSync_q[1] == clkSync_q[2]) ? clkSync_q[2] : clkLevel_q;
    datLevel_d = (datSync_q[1] == datSync_q[2]) ? datSync_q[2] : datLevel_q;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clkSync_q <= 3'h7;
      datSync_q <= 3'h0;
      clkLevel_q <= 1'b1;
      datLevel_q <= 1'b0;
    end else begin
      clkSync_q <= clkSync_d;
      datSync_q <= datSync_d;
      clkLevel_q <= clkLevel_d;
      datLevel_q <= datLevel_d;
    end
  end

  // edges of the host clock, seen through the filtered level
  assign rise = clkLevel_d && !clkLevel_q;
  assign fall = !clkLevel_d && clkLevel_q;

  // ---------------------------------------------------------------
  // frame decoder and register set
  // ---------------------------------------------------------------
  debug_link_pkg::devState_t state_q, state_d;
  logic [1:0] instr_q, instr_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [7:0] shift_q, shift_d;
  logic dataOut_q, dataOut_d, dataOe_q, dataOe_d;
  logic [7:0] select_q, select_d;
  logic [7:0] enableKey_q, enableKey_d;
  logic keyArmed_q, keyArmed_d;
  logic progEn_q, progEn_d;
  logic [7:0] dataPort_q, dataPort_d;
  logic cmdPending_q, cmdPending_d;
  logic [7:0] cmdCode_q, cmdCode_d;
  logic cmdStrobe_q, cmdStrobe_d, byteStrobe_q, byteStrobe_d;
  logic stall_q, stall_d;
  logic [1:0] curInstr;
  logic [7:0] wrByte, rdValue;
  logic validCmd;

  always_comb begin
    // first instruction bit was parked in the upper slot at the previous rise
    curInstr = {datLevel_q, instr_q[1]};
    wrByte = {datLevel_q, shift_q[7:1]};
    validCmd = (wrByte == `CMD_BLOCK_READ) || (wrByte == `CMD_BLOCK_WRITE) ||
               (wrByte == `CMD_PAGE_ERASE) || (wrByte == `CMD_DEVICE_ERASE);

    // read routing by the selected register
    if (curInstr == debug_link_pkg::INSTR_SELECT_READ) begin
      rdValue = select_q;
    end else if (select_q == `REG_PART_IDENTITY) begin
      rdValue = PART_ID;
    end else if (select_q == `REG_SILICON_REVISION) begin
      rdValue = REVISION;
    end else if (select_q == `REG_PROGRAM_ENABLE_KEY) begin
      rdValue = enableKey_q;
    end else if (select_q == `REG_PROGRAM_DATA_PORT) begin
      rdValue = dataPort_q;
    end else begin
      rdValue = `RESET_BYTE;
    end

    state_d = state_q;
    instr_d = instr_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    dataOut_d = dataOut_q;
    dataOe_d = dataOe_q;
    select_d = select_q;
    enableKey_d = enableKey_q;
    keyArmed_d = keyArmed_q;
    progEn_d = progEn_q;
    dataPort_d = dataPort_q;
    cmdPending_d = cmdPending_q;
    cmdCode_d = cmdCode_q;
    cmdStrobe_d = 1'b0;
    byteStrobe_d = 1'b0;
    // peripherals and software stall while halted and once programming is on
    stall_d = coreHalted || progEn_q;

    // finished flash step frees the port and returns read data through it
    if (flashDone) begin
      cmdPending_d = 1'b0;
      dataPort_d = flashReadData;
    end

    case (state_q)
      debug_link_pkg::DEV_IDLE: begin
        if (rise && datLevel_q) begin
          bitCnt_d = `COUNT_ZERO;
          state_d = debug_link_pkg::DEV_INSTR;
        end
      end
      debug_link_pkg::DEV_INSTR: begin
        if (rise) begin
          instr_d = curInstr;
          if (bitCnt_q == `INSTR_BIT_LAST) begin
            bitCnt_d = `COUNT_ZERO;
            if (curInstr == debug_link_pkg::INSTR_DATA_READ ||
                curInstr == debug_link_pkg::INSTR_SELECT_READ) begin
              shift_d = rdValue;
              state_d = debug_link_pkg::DEV_READ;
            end else begin
              state_d = debug_link_pkg::DEV_WRITE;
            end
          end else begin
            bitCnt_d = bitCnt_q + `COUNT_ONE;
          end
        end
      end
      debug_link_pkg::DEV_READ: begin
        // drive after each falling edge so the bit is steady at the next rise
        if (fall) begin
          dataOe_d = 1'b1;
          dataOut_d = shift_q[0];
          shift_d = {1'b0, shift_q[7:1]};
        end
        if (rise) begin
          bitCnt_d = bitCnt_q + `COUNT_ONE;
          if (bitCnt_q == `BYTE_BIT_LAST) begin
            dataOe_d = 1'b0;
            dataOut_d = 1'b0;
            state_d = debug_link_pkg::DEV_IDLE;
          end
        end
      end
      debug_link_pkg::DEV_WRITE: begin
        if (rise) begin
          shift_d = wrByte;
          bitCnt_d = bitCnt_q + `COUNT_ONE;
          if (bitCnt_q == `BYTE_BIT_LAST) begin
            state_d = debug_link_pkg::DEV_IDLE;
            if (instr_q == debug_link_pkg::INSTR_SELECT_WRITE) begin
              select_d = wrByte;
            end else if (select_q == `REG_PROGRAM_ENABLE_KEY) begin
              enableKey_d = wrByte;
              // any other write to the key register between the two codes disarms the sequence
              keyArmed_d = (wrByte == `KEY_FIRST);
              if (keyArmed_q && wrByte == `KEY_SECOND) begin
                progEn_d = 1'b1;
              end
            end else if (select_q == `REG_PROGRAM_DATA_PORT) begin
              dataPort_d = wrByte;
              if (progEn_q) begin
                if (!cmdPending_q && validCmd) begin
                  cmdPending_d = 1'b1;
                  cmdCode_d = wrByte;
                  cmdStrobe_d = 1'b1;
                end else if (cmdPending_q) begin
                  byteStrobe_d = 1'b1;
                end
              end
            end
            // identity and revision selects take no write
          end
        end
      end
      default: state_d = debug_link_pkg::DEV_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= debug_link_pkg::DEV_IDLE;
      instr_q <= 2'b00;
      bitCnt_q <= `COUNT_ZERO;
      shift_q <= `RESET_BYTE;
      dataOut_q <= 1'b0;
      dataOe_q <= 1'b0;
      select_q <= `RESET_SELECT;
      enableKey_q <= `RESET_ENABLE_KEY;
      keyArmed_q <= 1'b0;
      progEn_q <= 1'b0; // only a system reset ends programming mode
      dataPort_q <= `RESET_DATA_PORT;
      cmdPending_q <= 1'b0;
      cmdCode_q <= `RESET_BYTE;
      cmdStrobe_q <= 1'b0;
      byteStrobe_q <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      state_q <= state_d;
      instr_q <= instr_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      dataOut_q <= dataOut_d;
      dataOe_q <= dataOe_d;
      select_q <= select_d;
      enableKey_q <= enableKey_d;
      keyArmed_q <= keyArmed_d;
      progEn_q <= progEn_d;
      dataPort_q <= dataPort_d;
      cmdPending_q <= cmdPending_d;
      cmdCode_q <= cmdCode_d;
      cmdStrobe_q <= cmdStrobe_d;
      byteStrobe_q <= byteStrobe_d;
      stall_q <= stall_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.devDataOut = dataOut_q;
  assign link.devDataOe = dataOe_q;
  assign stallAll = stall_q;
  assign programEnabled = progEn_q;
  assign commandStrobe = cmdStrobe_q;
  assign commandCode = cmdCode_q;
  assign byteStrobe = byteStrobe_q;
  assign portByte = dataPort_q;

endmodule

`default_nettype wire

/* File: tb/debug_link_asserts.sv */
// concurrent checks on the signals of the two-wire debug link
`timescale 1ns/1ps
`default_nettype none

module debug_link_asserts #(
  parameter int HALF_CYCLES = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link
  input wire logic debugClockPin,
  input wire logic hostDataOut,
  input wire logic hostDataOe,
  input wire logic devDataOut,
  input wire logic devDataOe
);
  logic clkPrev_q;
  logic clkPrev_d;
  logic [3:0] riseCount_q;
  logic [3:0] riseCount_d;
  logic riseEdge;
  logic fallEdge;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // rise counter: 11 means idle, so a fall seen there opens a frame
  // ---------------------------------------------------------------
  assign riseEdge = debugClockPin && !clkPrev_q;
  assign fallEdge = !debugClockPin && clkPrev_q;

  always_comb begin
    clkPrev_d = debugClockPin;
    riseCount_d = riseCount_q;
    if (fallEdge && riseCount_q == 4'hb) begin
      riseCount_d = 4'h0;
    end else if (riseEdge) begin
      riseCount_d = riseCount_q + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clkPrev_q <= 1'b1;
      riseCount_q <= 4'hb;
    end else begin
      clkPrev_q <= clkPrev_d;
      riseCount_q <= riseCount_d;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sequence s_frame_start;
    fallEdge && riseCount_q == 4'hb;
  endsequence

  sequence s_last_rise;
    riseEdge && riseCount_q == 4'ha;
  endsequence

  property p_no_contention;
    !(hostDataOe && devDataOe);
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("both ends drive the data pin");

  property p_start_bit;
    s_frame_start |-> hostDataOe && hostDataOut;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("frame opened without a driven start bit");

  property p_low_half;
    fallEdge |-> ##HALF_CYCLES riseEdge;
  endproperty
  a_low_half: assert property (p_low_half)
    else $error("link clock low phase has wrong length");

  property p_high_half;
    riseEdge && riseCount_q < 4'ha |-> ##HALF_CYCLES fallEdge;
  endproperty
  a_high_half: assert property (p_high_half)
    else $error("link clock high phase has wrong length");

  property p_pulse_count;
    riseEdge |-> riseCount_q <= 4'ha;
  endproperty
  a_pulse_count: assert property (p_pulse_count)
    else $error("more than eleven clock pulses in a frame");

  property p_idle_high;
    riseCount_q == 4'hb && !fallEdge |-> debugClockPin;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("link clock not high between frames");

  property p_dev_window;
    $rose(devDataOe) |-> riseCount_q == 4'h3;
  endproperty
  a_dev_window: assert property (p_dev_window)
    else $error("device drove outside the data phase");

  property p_dev_release;
    s_last_rise |-> ##[1:8] !devDataOe;
  endproperty
  a_dev_release: assert property (p_dev_release)
    else $error("device kept the data pin after the frame");

  property p_host_bit_at_fall;
    hostDataOe && $changed(hostDataOut) |-> fallEdge;
  endproperty
  a_host_bit_at_fall: assert property (p_host_bit_at_fall)
    else $error("host data changed away from a falling clock");

  property p_dev_bit_stable;
    riseEdge && devDataOe |-> $stable(devDataOut);
  endproperty
  a_dev_bit_stable: assert property (p_dev_bit_stable)
    else $error("device data moved at the sampling edge");
endmodule

`default_nettype wire

/* File: tb/two_wire_debug_flash_regs_bench.sv */
// self-checking bench joining the host and device ends of the debug link
`timescale 1ns/1ps
`default_nettype none
`include "debug_link_regs.svh"

module two_wire_debug_flash_regs_bench;
  localparam int HALF = 16;
  // arbitrary identity values
  localparam logic [7:0] ID = 8'h3c;
  localparam logic [7:0] REV = 8'h0b;

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  debug_link_pkg::linkInstr_t reqInstr = debug_link_pkg::INSTR_DATA_READ;
  logic [7:0] reqData = 8'h00;
  logic reqReady, rspValid, stallAll, programEnabled, commandStrobe, byteStrobe;
  logic [7:0] rspData, commandCode, portByte;
  logic coreHalted = 1'b0;
  logic flashDone = 1'b0;
  logic [7:0] flashReadData = 8'h00;
  logic [7:0] cmdSeen = 8'h00;
  logic [7:0] byteSeen = 8'h00;
  logic [7:0] lastCmd = 8'h00;
  logic [7:0] lastByte = 8'h00;
  int n_mismatch = 0;
  int checks_done = 0;

  always #20 clock = ~clock;

  debug_link_if u_debug_link_if ();

  debug_port_host #(.HALF_CYCLES(HALF)) u_debug_port_host (
    .clock(clock), .rst_n(rst_n), .reqValid(reqValid), .reqInstr(reqInstr),
    .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .link(u_debug_link_if));

  debug_port_device #(.PART_ID(ID), .REVISION(REV)) u_debug_port_device (
    .clock(clock), .rst_n(rst_n), .coreHalted(coreHalted), .stallAll(stallAll),
    .programEnabled(programEnabled), .commandStrobe(commandStrobe),
    .commandCode(commandCode), .byteStrobe(byteStrobe), .portByte(portByte),
    .flashDone(flashDone), .flashReadData(flashReadData), .link(u_debug_link_if));

  debug_link_asserts #(.HALF_CYCLES(HALF)) u_debug_link_asserts (
    .clock(clock), .rst_n(rst_n), .debugClockPin(u_debug_link_if.debugClockPin),
    .hostDataOut(u_debug_link_if.hostDataOut), .hostDataOe(u_debug_link_if.hostDataOe),
    .devDataOut(u_debug_link_if.devDataOut), .devDataOe(u_debug_link_if.devDataOe));

  // strobes last one cycle, so they are tallied here rather than polled
  always @(posedge clock) begin
    if (commandStrobe === 1'b1) begin
      cmdSeen <= cmdSeen + 8'h01;
      lastCmd <= commandCode;
    end
    if (byteStrobe === 1'b1) begin
      byteSeen <= byteSeen + 8'h01;
      lastByte <= portByte;
    end
  end

  // ---------------------------------------------------------------
  // compare, report and transfer tasks
  // ---------------------------------------------------------------
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic xfer(input debug_link_pkg::linkInstr_t instr, input logic [7:0] data,
      output logic [7:0] rd);
    int n;
    // unknown until an answer arrives, so a missing read answer cannot match
    rd = 8'hxx;
    @(posedge clock);
    reqValid <= 1'b1;
    reqInstr <= instr;
    reqData <= data;
    @(posedge clock);
    reqValid <= 1'b0;
    for (n = 0; n < 2000; n++) begin
      @(negedge clock);
      if (rspValid === 1'b1) begin
        rd = rspData;
      end
      if (reqReady === 1'b1) begin
        break;
      end
    end
    if (n == 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  task automatic sel(input logic [7:0] a);
    logic [7:0] rd;
    xfer(debug_link_pkg::INSTR_SELECT_WRITE, a, rd);
  endtask

  task automatic wr(input logic [7:0] d);
    logic [7:0] rd;
    xfer(debug_link_pkg::INSTR_DATA_WRITE, d, rd);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] exp);
    logic [7:0] rd;
    xfer(debug_link_pkg::INSTR_DATA_READ, 8'h00, rd);
    check_byte(what, exp, rd);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_stall;
    @(negedge clock);
    check_bit("stallAll idle", 1'b0, stallAll);
    @(posedge clock);
    coreHalted <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    check_bit("stallAll halted", 1'b1, stallAll);
  endtask

  task automatic t_identity;
    logic [7:0] rd;
    rd_chk("part_identity", ID);
    wr(8'hff);
    rd_chk("part_identity kept", ID);
    sel(`REG_SILICON_REVISION);
    xfer(debug_link_pkg::INSTR_SELECT_READ, 8'h00, rd);
    check_byte("debug_register_select", `REG_SILICON_REVISION, rd);
    rd_chk("silicon_revision", REV);
    wr(8'h00);
    rd_chk("silicon_revision kept", REV);
  endtask

  task automatic t_key;
    sel(`REG_PROGRAM_ENABLE_KEY);
    rd_chk("program_enable_key reset", `RESET_ENABLE_KEY);
    wr(`KEY_SECOND);
    wr(`KEY_FIRST);
    wr(8'h05);
    wr(`KEY_SECOND);
    check_bit("programEnabled bad order", 1'b0, programEnabled);
    wr(`KEY_FIRST);
    wr(`KEY_SECOND);
    check_bit("programEnabled", 1'b1, programEnabled);
    rd_chk("program_enable_key", `KEY_SECOND);
    @(posedge clock);
    coreHalted <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check_bit("stallAll programming", 1'b1, stallAll);
  endtask

  task automatic t_commands;
    logic [7:0] codes [4] = '{`CMD_BLOCK_READ, `CMD_BLOCK_WRITE, `CMD_PAGE_ERASE,
        `CMD_DEVICE_ERASE};
    sel(`REG_PROGRAM_DATA_PORT);
    rd_chk("program_data_port reset", `RESET_DATA_PORT);
    wr(8'h55);
    check_byte("command count invalid", 8'h00, cmdSeen);
    for (int i = 0; i < 4; i++) begin
      wr(codes[i]);
      check_byte("command count", 8'(i + 1), cmdSeen);
      check_byte("commandCode", codes[i], lastCmd);
      wr(8'h40 + 8'(i));
      check_byte("byte count", 8'(i + 1), byteSeen);
      check_byte("portByte", 8'h40 + 8'(i), lastByte);
      @(posedge clock);
      flashDone <= 1'b1;
      flashReadData <= 8'hc0 + 8'(i);
      @(posedge clock);
      flashDone <= 1'b0;
      rd_chk("program_data_port read", 8'hc0 + 8'(i));
    end
  endtask

  task automatic t_sys_reset;
    check_bit("programEnabled held", 1'b1, programEnabled);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check_bit("programEnabled after reset", 1'b0, programEnabled);
    sel(`REG_PROGRAM_ENABLE_KEY);
    rd_chk("program_enable_key after reset", `RESET_ENABLE_KEY);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_stall();
    t_identity();
    t_key();
    t_commands();
    t_sys_reset();
    report_and_stop();
  end
endmodule

`default_nettype wire
